// File: pkg/sram_tap_map.svh
// constants for the sram boundary scan test port
`ifndef SRAM_TAP_MAP_SVH
`define SRAM_TAP_MAP_SVH
`define TAP_IR_W 3
`define TAP_IR_CAPTURE 3'h1
`define TAP_OP_EXTEST 3'h0
`define TAP_ID_W 32
`define TAP_BSR_W 16
`define TAP_RST_TMS_EDGES 3'h5
`endif

// File: pkg/sram_tap_pkg.sv
// types shared by the sram boundary scan test port
package sram_tap_pkg;
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008,
        ST_SHDR = 16'h0010,
        ST_EX1DR = 16'h0020,
        ST_PSDR = 16'h0040,
        ST_EX2DR = 16'h0080,
        ST_UPDR = 16'h0100,
        ST_SELIR = 16'h0200,
        ST_CAPIR = 16'h0400,
        ST_SHIR = 16'h0800,
        ST_EX1IR = 16'h1000,
        ST_PSIR = 16'h2000,
        ST_EX2IR = 16'h4000,
        ST_UPIR = 16'h8000
    } tap_state_t;
    typedef enum logic [2:0] {
        SEL_BSR = 3'h1,
        SEL_ID = 3'h2,
        SEL_BYP = 3'h4
    } dr_sel_t;
    typedef struct packed {
        dr_sel_t sel;
        logic hiz;
    } ir_dec_t;
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;
endpackage : sram_tap_pkg

// File: src/tap_fsm.sv
// test access port controller state machine
`timescale 1ns/1ns
`default_nettype none
`include "sram_tap_map.svh"
module tap_fsm (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_tck_rise,
    input wire logic i_tms,
    output var sram_tap_pkg::tap_state_t o_state
);
    logic [2:0] hi_cnt_reg;

    // next state from tms at a rise; ones reach reset
    function automatic sram_tap_pkg::tap_state_t next_state(
        input sram_tap_pkg::tap_state_t s, input logic tms);
        case (s)
            sram_tap_pkg::ST_TLR: next_state = tms ? sram_tap_pkg::ST_TLR
                                                   : sram_tap_pkg::ST_RTI;
            sram_tap_pkg::ST_RTI: next_state = tms ? sram_tap_pkg::ST_SELDR
                                                   : sram_tap_pkg::ST_RTI;
            sram_tap_pkg::ST_SELDR: next_state = tms ? sram_tap_pkg::ST_SELIR
                                                     : sram_tap_pkg::ST_CAPDR;
            sram_tap_pkg::ST_CAPDR: next_state = tms ? sram_tap_pkg::ST_EX1DR
                                                     : sram_tap_pkg::ST_SHDR;
            sram_tap_pkg::ST_SHDR: next_state = tms ? sram_tap_pkg::ST_EX1DR
                                                    : sram_tap_pkg::ST_SHDR;
            sram_tap_pkg::ST_EX1DR: next_state = tms ? sram_tap_pkg::ST_UPDR
                                                     : sram_tap_pkg::ST_PSDR;
            sram_tap_pkg::ST_PSDR: next_state = tms ? sram_tap_pkg::ST_EX2DR
                                                    : sram_tap_pkg::ST_PSDR;
            sram_tap_pkg::ST_EX2DR: next_state = tms ? sram_tap_pkg::ST_UPDR
                                                     : sram_tap_pkg::ST_SHDR;
            sram_tap_pkg::ST_UPDR: next_state = tms ? sram_tap_pkg::ST_SELDR
                                                    : sram_tap_pkg::ST_RTI;
            sram_tap_pkg::ST_SELIR: next_state = tms ? sram_tap_pkg::ST_TLR
                                                     : sram_tap_pkg::ST_CAPIR;
            sram_tap_pkg::ST_CAPIR: next_state = tms ? sram_tap_pkg::ST_EX1IR
                                                     : sram_tap_pkg::ST_SHIR;
            sram_tap_pkg::ST_SHIR: next_state = tms ? sram_tap_pkg::ST_EX1IR
                                                    : sram_tap_pkg::ST_SHIR;
            sram_tap_pkg::ST_EX1IR: next_state = tms ? sram_tap_pkg::ST_UPIR
                                                     : sram_tap_pkg::ST_PSIR;
            sram_tap_pkg::ST_PSIR: next_state = tms ? sram_tap_pkg::ST_EX2IR
                                                    : sram_tap_pkg::ST_PSIR;
            sram_tap_pkg::ST_EX2IR: next_state = tms ? sram_tap_pkg::ST_UPIR
                                                     : sram_tap_pkg::ST_SHIR;
            sram_tap_pkg::ST_UPIR: next_state = tms ? sram_tap_pkg::ST_SELDR
                                                    : sram_tap_pkg::ST_RTI;
            default: next_state = sram_tap_pkg::ST_TLR;
        endcase
    endfunction : next_state

    // state advances only on a detected test clock rise
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_state <= sram_tap_pkg::ST_TLR;
        end else if (i_tck_rise) begin
            o_state <= next_state(o_state, i_tms);
        end
    end

    // run of consecutive rises with tms high, seen only by a check
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            hi_cnt_reg <= 3'h0;
        end else if (i_tck_rise) begin
            if (!i_tms) begin
                hi_cnt_reg <= 3'h0;
            end else if (hi_cnt_reg != `TAP_RST_TMS_EDGES) begin
                hi_cnt_reg <= hi_cnt_reg + 3'h1;
            end
        end
    end

    five_tms_a: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_tck_rise && i_tms && hi_cnt_reg == 3'h4)
        |=> o_state == sram_tap_pkg::ST_TLR)
        else $error("five tms high rises did not reach reset state");
endmodule : tap_fsm
`default_nettype wire

// File: src/sram_tap.sv
// boundary scan test port: instruction decode and data registers
`timescale 1ns/1ns
`default_nettype none
`include "sram_tap_map.svh"
// Notes on behaviour
// - three-bit instruction, four opcodes decoded, all others select bypass
// - no drive into core or pin buffers
// - test opcodes only capture the pin ring
// - opcode shifts in, applies at Update-IR
// - all-zero opcode acts as high-z sample, boundary selected
// - all-zero opcode forces data outputs high-z
// - identification captures fixed 32-bit value, shifts out
// - identification opcode after reset and Test-Logic-Reset
// - high-z sample selects boundary, outputs high-z
// - sample latches pin snapshot in Capture-DR
// - Shift-DR after capture shifts boundary out
// - Update-DR under sample changes nothing
// - bypass opcode puts bypass bit alone
// - Capture-IR loads 01 into low bits
// - bypass is one bit, cleared on capture
// - five tms-high rises reset test logic
// - sample on rising, drive tdo on falling
module sram_tap #(
    parameter logic [2:0] OP_IDCODE = 3'h1,
    parameter logic [2:0] OP_SAMPLE_Z = 3'h2,
    parameter logic [2:0] OP_SAMPLE = 3'h4,
    parameter logic [2:0] OP_BYPASS = 3'h7,
    // arbitrary identification value
    parameter logic [31:0] ID_VALUE = 32'h0A5A_5001
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire sram_tap_pkg::tap_pins_t i_tap,
    input wire logic [`TAP_BSR_W-1:0] i_ring,
    output logic o_tdo,
    output logic o_tdo_oe,
    output logic o_dq_hiz,
    output logic [`TAP_IR_W-1:0] o_ir
);
    sram_tap_pkg::tap_pins_t pins_s1_reg;
    sram_tap_pkg::tap_pins_t pins_s2_reg;
    logic tck_s3_reg;
    logic [`TAP_BSR_W-1:0] ring_s1_reg;
    logic [`TAP_BSR_W-1:0] ring_s2_reg;
    logic tck_rise;
    logic tck_fall;
    sram_tap_pkg::tap_state_t state;
    logic [`TAP_IR_W-1:0] ir_shift_reg;
    logic [`TAP_BSR_W-1:0] bsr_reg;
    logic [`TAP_ID_W-1:0] id_reg;
    logic byp_reg;
    sram_tap_pkg::ir_dec_t dec;
    logic tdo_next;
    logic oe_next;

    function automatic sram_tap_pkg::ir_dec_t decode(
        input logic [`TAP_IR_W-1:0] op);
        decode.sel = sram_tap_pkg::SEL_BYP;
        decode.hiz = 1'b0;
        if (op == `TAP_OP_EXTEST) begin
            decode.sel = sram_tap_pkg::SEL_BSR;
            decode.hiz = 1'b1;
        end else if (op == OP_IDCODE) begin
            decode.sel = sram_tap_pkg::SEL_ID;
        end else if (op == OP_SAMPLE_Z) begin
            decode.sel = sram_tap_pkg::SEL_BSR;
            decode.hiz = 1'b1;
        end else if (op == OP_SAMPLE) begin
            decode.sel = sram_tap_pkg::SEL_BSR;
        end
    endfunction : decode

    // two-flop synchronisers; the third tck flop only finds edges
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pins_s1_reg <= '0;
            pins_s2_reg <= '0;
            tck_s3_reg <= 1'b0;
        end else begin
            pins_s1_reg <= i_tap;
            pins_s2_reg <= pins_s1_reg;
            tck_s3_reg <= pins_s2_reg.tck;
        end
    end

    // ring is sampled like any pin; unstable pins give no promise
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ring_s1_reg <= '0;
            ring_s2_reg <= '0;
        end else begin
            ring_s1_reg <= i_ring;
            ring_s2_reg <= ring_s1_reg;
        end
    end

    // edges of the sampled test clock
    assign tck_rise = pins_s2_reg.tck & ~tck_s3_reg;
    assign tck_fall = ~pins_s2_reg.tck & tck_s3_reg;

    tap_fsm u_fsm (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_tck_rise(tck_rise),
        .i_tms(pins_s2_reg.tms),
        .o_state(state)
    );

    assign dec = decode(o_ir);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ir_shift_reg <= `TAP_IR_CAPTURE;
            o_ir <= OP_IDCODE;
        end else if (tck_rise) begin
            case (state)
                sram_tap_pkg::ST_TLR: o_ir <= OP_IDCODE;
                sram_tap_pkg::ST_CAPIR: ir_shift_reg <= `TAP_IR_CAPTURE;
                sram_tap_pkg::ST_SHIR: begin
                    ir_shift_reg <= {pins_s2_reg.tdi, ir_shift_reg[2:1]};
                end
                sram_tap_pkg::ST_UPIR: o_ir <= ir_shift_reg;
                default: begin
                end
            endcase
        end
    end

    // data registers; no path leads back into the core or pin drivers
    // capture only, never apply
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bsr_reg <= '0;
            id_reg <= '0;
            byp_reg <= 1'b0;
        end else if (tck_rise) begin
            case (state)
                sram_tap_pkg::ST_CAPDR: begin
                    case (dec.sel)
                        sram_tap_pkg::SEL_BSR: bsr_reg <= ring_s2_reg;
                        sram_tap_pkg::SEL_ID: id_reg <= ID_VALUE;
                        default: byp_reg <= 1'b0;
                    endcase
                end
                sram_tap_pkg::ST_SHDR: begin
                    case (dec.sel)
                        sram_tap_pkg::SEL_BSR: begin
                            bsr_reg <= {pins_s2_reg.tdi,
                                        bsr_reg[`TAP_BSR_W-1:1]};
                        end
                        sram_tap_pkg::SEL_ID: begin
                            id_reg <= {pins_s2_reg.tdi,
                                       id_reg[`TAP_ID_W-1:1]};
                        end
                        default: byp_reg <= pins_s2_reg.tdi;
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    // serial output from the low bit of the selected register
    always_comb begin
        tdo_next = 1'b0;
        oe_next = 1'b0;
        case (state)
            sram_tap_pkg::ST_SHIR: begin
                tdo_next = ir_shift_reg[0];
                oe_next = 1'b1;
            end
            sram_tap_pkg::ST_SHDR: begin
                oe_next = 1'b1;
                case (dec.sel)
                    sram_tap_pkg::SEL_BSR: tdo_next = bsr_reg[0];
                    sram_tap_pkg::SEL_ID: tdo_next = id_reg[0];
                    default: tdo_next = byp_reg;
                endcase
            end
            default: begin
            end
        endcase
    end

    // tdo changes on the falling edge
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            o_tdo <= tdo_next;
            o_tdo_oe <= oe_next;
        end
    end

    // outputs high-z for the all-zero and high-z sample codes
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_dq_hiz <= 1'b0;
        end else begin
            o_dq_hiz <= dec.hiz;
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    sequence cap_dr_s;
        tck_rise && state == sram_tap_pkg::ST_CAPDR;
    endsequence
    sequence rise_in_s(sram_tap_pkg::tap_state_t st);
        tck_rise && state == st;
    endsequence

    ir_reset_a: assert property (
        rise_in_s(sram_tap_pkg::ST_TLR) |=> o_ir == OP_IDCODE)
        else $error("instruction not identification after reset state");
    ir_capture_a: assert property (
        rise_in_s(sram_tap_pkg::ST_CAPIR) |=> ir_shift_reg == 3'h1)
        else $error("capture-ir pattern wrong");
    // opcode applies only at update or reset state
    ir_update_a: assert property (
        !(tck_rise && (state == sram_tap_pkg::ST_UPIR
            || state == sram_tap_pkg::ST_TLR)) |=> $stable(o_ir))
        else $error("instruction changed outside update");
    extest_hiz_a: assert property (
        o_ir == 3'h0 && $stable(o_ir) |=> o_dq_hiz)
        else $error("all-zero opcode without high-z outputs");
    samplez_sel_a: assert property (
        o_ir == OP_SAMPLE_Z |-> dec.sel == sram_tap_pkg::SEL_BSR && dec.hiz)
        else $error("high-z sample decode wrong");
    // sample keeps outputs driven, boundary chosen
    sample_sel_a: assert property (
        o_ir == OP_SAMPLE ##1 o_ir == OP_SAMPLE
        |-> !o_dq_hiz && dec.sel == sram_tap_pkg::SEL_BSR)
        else $error("sample decode wrong");
    id_capture_a: assert property (
        cap_dr_s and o_ir == OP_IDCODE |=> id_reg == ID_VALUE)
        else $error("identification value not captured");
    bsr_capture_a: assert property (
        cap_dr_s and o_ir == OP_SAMPLE |=> bsr_reg == $past(ring_s2_reg))
        else $error("pin snapshot not captured");
    byp_clear_a: assert property (
        cap_dr_s and o_ir == OP_BYPASS |=> !byp_reg)
        else $error("bypass bit not cleared");
    update_dr_a: assert property (
        rise_in_s(sram_tap_pkg::ST_UPDR)
        |=> $stable(bsr_reg) && $stable(id_reg) && $stable(byp_reg))
        else $error("update-dr altered a data register");
    // tdo moves only after a falling edge
    tdo_fall_a: assert property (
        !tck_fall |=> $stable(o_tdo))
        else $error("tdo changed without a falling edge");
endmodule : sram_tap
`default_nettype wire

// File: verification/scan_tester.sv
// behavioural board-level scan tester driving the test port pins
`timescale 1ns/1ns
`default_nettype none
`include "sram_tap_map.svh"
module scan_tester (
    input wire logic i_sys_clk,
    input wire logic i_tdo,
    output var sram_tap_pkg::tap_pins_t o_tap
);
    // pins rest high as the pull-ups leave them, test clock parked low
    initial begin
        o_tap = 3'h3;
    end

    // slow clock cycle
    // 800 ns period: low 5 sys clocks, tdo read just before the rise
    task automatic cycle(input logic tms, input logic tdi, output logic tdo);
        o_tap.tck = 1'b0;
        o_tap.tms = tms;
        o_tap.tdi = tdi;
        repeat (5) @(negedge i_sys_clk);
        tdo = i_tdo;
        o_tap.tck = 1'b1;
        repeat (3) @(negedge i_sys_clk);
    endtask : cycle

    // clock stands still between frames, pins back to pull-up level
    // one sys clock of rest so the next frame never rewrites in the same step
    task automatic park();
        o_tap = 3'h3;
        @(negedge i_sys_clk);
    endtask : park

    // tms sequence, lsb first
    task automatic moves(input logic [7:0] seq, input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            cycle(seq[i], 1'b1, d);
        end
    endtask : moves

    // five tms high rises, then idle
    task automatic reset_tap();
        moves(8'h1F, 6);
        park();
    endtask : reset_tap

    task automatic load_ir(input logic [2:0] op, output logic [2:0] cap);
        moves(8'h03, 4);
        for (int i = 0; i < 3; i++) begin
            cycle(i == 2, op[i], cap[i]);
        end
        moves(8'h01, 2);
        park();
    endtask : load_ir

    // capture, shift n bits, update and back to idle
    task automatic scan_dr(input int n, input logic [31:0] din,
                           output logic [31:0] dout);
        dout = 32'h0;
        moves(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            cycle(i == n - 1, din[i], dout[i]);
        end
        moves(8'h01, 2);
        park();
    endtask : scan_dr
endmodule : scan_tester
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the sram boundary scan test port
`timescale 1ns/1ns
`default_nettype none
`include "sram_tap_map.svh"
module testbench;
    localparam logic [2:0] OP_ID = 3'h1;
    localparam logic [2:0] OP_SZ = 3'h2;
    localparam logic [2:0] OP_SP = 3'h4;
    localparam logic [2:0] OP_BY = 3'h7;
    // arbitrary identification value
    localparam logic [31:0] ID_VAL = 32'h1357_9BDF;
    logic sys_clk;
    logic rst;
    sram_tap_pkg::tap_pins_t tap;
    logic [`TAP_BSR_W-1:0] ring;
    logic tdo;
    logic tdo_oe;
    logic dq_hiz;
    logic [`TAP_IR_W-1:0] ir;
    wire logic tdo_line;
    int n_fail = 0;
    int check_count = 0;

    // released tdo has no pull; show the inverse so stray reads stand out
    assign tdo_line = tdo_oe ? tdo : ~tdo;

    sram_tap #(.OP_IDCODE(OP_ID), .OP_SAMPLE_Z(OP_SZ), .OP_SAMPLE(OP_SP),
               .OP_BYPASS(OP_BY), .ID_VALUE(ID_VAL)) i_dut (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_tap(tap), .i_ring(ring),
        .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_dq_hiz(dq_hiz), .o_ir(ir));

    scan_tester i_tester (.i_sys_clk(sys_clk), .i_tdo(tdo_line), .o_tap(tap));

    // 10 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // output registers trail the detected tck edge by a few sys clocks
    task automatic settle();
        repeat (6) @(negedge sys_clk);
    endtask : settle

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    task automatic t_reset();
        rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        settle();
        check(ir, OP_ID, "ir after reset");
        check(dq_hiz, 0, "hiz after reset");
        check(tdo_oe, 0, "tdo released after reset");
        i_tester.reset_tap();
    endtask : t_reset

    task automatic t_idcode();
        logic [31:0] d;
        logic [2:0] cap;
        i_tester.scan_dr(32, 32'h0, d);
        check(d, ID_VAL, "id shifted out");
        i_tester.load_ir(OP_ID, cap);
        check(cap, 3'h1, "ir capture pattern");
    endtask : t_idcode

    // every legal opcode: active code, hiz level and selected register
    task automatic t_opcodes();
        logic [31:0] d;
        logic [2:0] cap;
        logic [2:0] op;
        for (int k = 0; k < 8; k++) begin
            op = k[2:0];
            // reserved codes are never loaded by the tester
            if (op != 3'h0 && op != OP_ID && op != OP_SZ && op != OP_SP
                    && op != OP_BY) begin
                continue;
            end
            ring = 16'hC3A0 ^ {13'h0, op};
            i_tester.load_ir(op, cap);
            settle();
            check(ir, op, "active opcode");
            check(dq_hiz, (op == 3'h0 || op == OP_SZ), "hiz level");
            if (op == 3'h0 || op == OP_SZ || op == OP_SP) begin
                i_tester.scan_dr(16, 32'h5A5A, d);
                check(d, ring, "ring captured");
                ring = ~ring;
                settle();
                i_tester.scan_dr(16, 32'h0, d);
                check(d, ring, "no preload from scan");
                check(ir, op, "opcode kept over update");
            end else if (op == OP_ID) begin
                i_tester.scan_dr(32, 32'hFFFF_FFFF, d);
                check(d, ID_VAL, "id under opcode");
            end else begin
                i_tester.scan_dr(8, 32'hB5, d);
                check(d, 32'h6A, "one bit bypass delay");
            end
            settle();
            check(tdo_oe, 0, "tdo released in idle");
        end
    endtask : t_opcodes

    task automatic t_tms_reset();
        logic [2:0] cap;
        i_tester.load_ir(3'h0, cap);
        settle();
        check(dq_hiz, 1, "hiz under all-zero code");
        i_tester.reset_tap();
        settle();
        check(ir, OP_ID, "ir after tms reset");
        check(dq_hiz, 0, "hiz cleared by tms reset");
    endtask : t_tms_reset

    // main sequence
    initial begin
        rst = 1'b1;
        ring = 16'h0;
        @(negedge sys_clk);
        t_reset();
        t_idcode();
        t_opcodes();
        t_tms_reset();
        summarize();
    end

    // run needs well under a millisecond
    initial begin
        #2000000;
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end
endmodule : testbench
`default_nettype wire
